/* File: cfg_byte_reg.sv */
module cfg_byte_reg #(
  parameter logic [7:0] RESET_VAL = 8'h00,
  parameter logic [7:0] WR_MASK   = 8'hFF
) (
  // Clock, reset, enable
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       ce,
  // Write side
  input  wire logic       wr_en,
  input  wire logic [7:0] wr_data,
  // Stored value
  output logic [7:0]      value_q
);

  // Holds the last written value; masked bits never store a one from a write, only from RESET_VAL
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      value_q <= RESET_VAL;
    end else if (ce && wr_en) begin
      value_q <= wr_data & WR_MASK;
    end
  end

endmodule : cfg_byte_reg

/* File: conv_cfg_pkg.sv */
package conv_cfg_pkg;

  // Register addresses on the host register port
  localparam logic [7:0] ADDR_OUTPUT_DRIVER_CONFIG    = 8'hD8;
  localparam logic [7:0] ADDR_CURRENT_MONITOR_CONFIG  = 8'hD9;
  localparam logic [7:0] ADDR_INPUT_OV_THRESHOLD      = 8'hDA;

  // Values after reset
  localparam logic [7:0] RST_OUTPUT_DRIVER_CONFIG     = 8'h84;
  localparam logic [7:0] RST_CURRENT_MONITOR_CONFIG   = 8'h2C;
  localparam logic [7:0] RST_INPUT_OV_THRESHOLD       = 8'hFF;

  // Writable bit masks; cleared bits are unimplemented and read as zero
  localparam logic [7:0] MASK_OUTPUT_DRIVER_CONFIG    = 8'hFF;
  localparam logic [7:0] MASK_CURRENT_MONITOR_CONFIG  = 8'h3F;
  localparam logic [7:0] MASK_INPUT_OV_THRESHOLD      = 8'hFF;

  // Field positions in the output/driver configuration register
  localparam int FB_RATIO_BIT      = 7;
  localparam int LLC_ENABLE_BIT    = 6;
  localparam int LLC_GAIN_LSB      = 4;
  localparam int AUX_SEQ_LSB       = 2;
  localparam int AUX_SUP_LSB       = 0;

  // Field positions in the current-monitor configuration register
  localparam int CURRENT_SET_PIN_OVERRIDE_BIT = 5;
  localparam int WIN_LOW_LSB       = 0;

  // Scaling of the analog settings
  localparam logic [11:0] LLC_GAIN_BASE_MV = 12'h0FA;   // 250 mV at code 0
  localparam logic [9:0]  WIN_STEP_PERMIL  = 10'h019;   // 2.5 percent a code
  localparam logic [15:0] OV_BASE_MV       = 16'h128E;  // 4750 mV at code 0
  localparam logic [15:0] OV_STEP_MV       = 16'h007D;  // 125 mV a code

  // Auxiliary driver sequencing modes, in field code order
  typedef enum logic [1:0] {
    SEQ_LOW_WHEN_OFF,
    SEQ_LOW_WHEN_ON,
    SEQ_FORCE_ACTIVE,
    SEQ_FORCE_OFF
  } aux_seq_t;

  // Auxiliary driver supply styles, in field code order
  typedef enum logic [1:0] {
    SUP_OPEN_DRAIN,
    SUP_OUTPUT_RAIL,
    SUP_BIAS,
    SUP_CHARGE_PUMP
  } aux_sup_t;

endpackage : conv_cfg_pkg

/* File: conv_cfg_regs.sv */
// Overview of operation
// - Bit 7 picks feedback divide 10 or 20
// - Bit 6 enables line-loss compensation, reset off
// - Bits 5:4 gain 0.25, 0.5, 1, 2 V
// - Bits 3:2 choose auxiliary driver sequencing mode
// - Bits 1:0 choose auxiliary driver supply style
// - Monitor bits 7:6 ignore writes, read zero
// - Monitor bit 5 hands current set to pin
// - Window low threshold is code times 2.5%
// - Overvoltage threshold 4.75 V plus 0.125 V/code
// - Monitor register at 0xD9, resets 0x2C
// - Overvoltage register at 0xDA, resets 0xFF
// - Output/driver register at 0xD8, resets 0x84
module conv_cfg_regs (
  // Clock, reset, enable
  input  wire logic        I_CLK,
  input  wire logic        I_RST_N,
  input  wire logic        I_CE,
  // Register port from the serial interface engine
  input  wire logic [7:0]  I_REG_ADDR,
  input  wire logic        I_REG_WR,
  input  wire logic [7:0]  I_REG_WDATA,
  input  wire logic        I_REG_RD,
  output logic [7:0]       O_REG_RDATA,
  output logic             O_REG_RVALID,
  output logic             O_REG_HIT,
  // Feedback and line-loss compensation controls
  output logic             O_FB_DIV20,
  output logic             O_LLC_ENABLE,
  output logic [1:0]       O_LLC_GAIN,
  output logic [11:0]      O_LLC_GAIN_MV,
  // Auxiliary FET driver controls
  output logic [1:0]       O_AUX_SEQ,
  output logic [1:0]       O_AUX_SUPPLY,
  output logic             O_AUX_FORCE_ACTIVE,
  output logic             O_AUX_FORCE_OFF,
  output logic             O_AUX_LOW_WHEN_ON,
  output logic             O_AUX_OPEN_DRAIN,
  // Current set pin and monitor window
  output logic             O_CURRENT_SET_PIN_PIN_ACTIVE,
  output logic             O_CURRENT_LIMIT_DAC_DAC_ENABLE,
  output logic [4:0]       O_WIN_LOW_CODE,
  output logic [9:0]       O_WIN_LOW_PERMIL,
  output logic             O_WIN_LOW_ENABLE,
  // Input overvoltage threshold
  output logic [7:0]       O_IN_OV_CODE,
  output logic [15:0]      O_IN_OV_MV
);

  logic [7:0] odc_q;
  logic [7:0] cmc_q;
  logic [7:0] ovt_q;

  // Output values after reset, taken from the register reset values so the
  // scaled outputs can never disagree with the stored codes
  localparam logic [7:0] ODC_RST =
    conv_cfg_pkg::RST_OUTPUT_DRIVER_CONFIG;
  localparam logic [7:0] CMC_RST =
    conv_cfg_pkg::RST_CURRENT_MONITOR_CONFIG;
  localparam logic [7:0] OVT_RST =
    conv_cfg_pkg::RST_INPUT_OV_THRESHOLD;
  localparam logic [1:0] SEQ_RST =
    ODC_RST[conv_cfg_pkg::AUX_SEQ_LSB +: 2];
  localparam logic [1:0] SUP_RST =
    ODC_RST[conv_cfg_pkg::AUX_SUP_LSB +: 2];
  localparam logic [1:0] GAIN_RST =
    ODC_RST[conv_cfg_pkg::LLC_GAIN_LSB +: 2];
  localparam logic [4:0] WIN_RST =
    CMC_RST[conv_cfg_pkg::WIN_LOW_LSB +: 5];
  localparam logic [9:0] WIN_PERMIL_RST =
    10'(WIN_RST) * conv_cfg_pkg::WIN_STEP_PERMIL;
  localparam logic [11:0] GAIN_MV_RST =
    conv_cfg_pkg::LLC_GAIN_BASE_MV << GAIN_RST;
  localparam logic [15:0] OV_MV_RST = conv_cfg_pkg::OV_BASE_MV +
    16'(OVT_RST) * conv_cfg_pkg::OV_STEP_MV;

  // Address decode of the three registers
  wire sel_odc = (I_REG_ADDR == conv_cfg_pkg::ADDR_OUTPUT_DRIVER_CONFIG);
  wire sel_cmc = (I_REG_ADDR == conv_cfg_pkg::ADDR_CURRENT_MONITOR_CONFIG);
  wire sel_ovt = (I_REG_ADDR == conv_cfg_pkg::ADDR_INPUT_OV_THRESHOLD);
  wire sel_any = sel_odc | sel_cmc | sel_ovt;

  // Per-register write strobes; unmapped writes fall away
  wire wr_odc = I_REG_WR & sel_odc;
  wire wr_cmc = I_REG_WR & sel_cmc;
  wire wr_ovt = I_REG_WR & sel_ovt;

  // Output/driver configuration storage
  cfg_byte_reg #(
    .RESET_VAL (conv_cfg_pkg::RST_OUTPUT_DRIVER_CONFIG),
    .WR_MASK   (conv_cfg_pkg::MASK_OUTPUT_DRIVER_CONFIG)
  ) u_odc (
    .clk     (I_CLK),
    .rst_n   (I_RST_N),
    .ce      (I_CE),
    .wr_en   (wr_odc),
    .wr_data (I_REG_WDATA),
    .value_q (odc_q)
  );

  // Current-monitor configuration storage, top two bits unimplemented
  cfg_byte_reg #(
    .RESET_VAL (conv_cfg_pkg::RST_CURRENT_MONITOR_CONFIG),
    .WR_MASK   (conv_cfg_pkg::MASK_CURRENT_MONITOR_CONFIG)
  ) u_cmc (
    .clk     (I_CLK),
    .rst_n   (I_RST_N),
    .ce      (I_CE),
    .wr_en   (wr_cmc),
    .wr_data (I_REG_WDATA),
    .value_q (cmc_q)
  );

  // Input overvoltage threshold storage
  cfg_byte_reg #(
    .RESET_VAL (conv_cfg_pkg::RST_INPUT_OV_THRESHOLD),
    .WR_MASK   (conv_cfg_pkg::MASK_INPUT_OV_THRESHOLD)
  ) u_ovt (
    .clk     (I_CLK),
    .rst_n   (I_RST_N),
    .ce      (I_CE),
    .wr_en   (wr_ovt),
    .wr_data (I_REG_WDATA),
    .value_q (ovt_q)
  );

  // Read selection; unmapped addresses read zero
  wire [7:0] rd_mux = sel_odc ? odc_q :
                      sel_cmc ? cmc_q :
                      sel_ovt ? ovt_q : 8'h00;

  // Field extraction from stored values
  wire [1:0] gain_code = odc_q[conv_cfg_pkg::LLC_GAIN_LSB +: 2];
  wire [1:0] seq_code  = odc_q[conv_cfg_pkg::AUX_SEQ_LSB +: 2];
  wire [1:0] sup_code  = odc_q[conv_cfg_pkg::AUX_SUP_LSB +: 2];
  wire [4:0] win_code  = cmc_q[conv_cfg_pkg::WIN_LOW_LSB +: 5];

  wire conv_cfg_pkg::aux_seq_t seq_mode = conv_cfg_pkg::aux_seq_t'(seq_code);
  wire conv_cfg_pkg::aux_sup_t sup_mode = conv_cfg_pkg::aux_sup_t'(sup_code);

  // Scaled analog settings
  wire [11:0] gain_mv =
    conv_cfg_pkg::LLC_GAIN_BASE_MV << gain_code;
  wire [9:0] win_permil =
    10'(win_code) * conv_cfg_pkg::WIN_STEP_PERMIL;
  wire [15:0] ov_mv = conv_cfg_pkg::OV_BASE_MV +
    16'(ovt_q) * conv_cfg_pkg::OV_STEP_MV;

  // Read answer, one cycle after the request
  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      O_REG_RDATA  <= 8'h00;
      O_REG_RVALID <= 1'b0;
      O_REG_HIT    <= 1'b0;
    end else if (I_CE) begin
      O_REG_RVALID <= I_REG_RD;
      O_REG_HIT    <= (I_REG_RD | I_REG_WR) & sel_any;
      if (I_REG_RD) begin
        O_REG_RDATA <= rd_mux;
      end
    end
  end

  // Feedback and line-loss compensation outputs
  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      O_FB_DIV20    <= ODC_RST[conv_cfg_pkg::FB_RATIO_BIT];
      O_LLC_ENABLE  <= ODC_RST[conv_cfg_pkg::LLC_ENABLE_BIT];
      O_LLC_GAIN    <= GAIN_RST;
      O_LLC_GAIN_MV <= GAIN_MV_RST;
    end else if (I_CE) begin
      O_FB_DIV20    <= odc_q[conv_cfg_pkg::FB_RATIO_BIT];
      O_LLC_ENABLE  <= odc_q[conv_cfg_pkg::LLC_ENABLE_BIT];
      O_LLC_GAIN    <= gain_code;
      O_LLC_GAIN_MV <= gain_mv;
    end
  end

  // Auxiliary driver mode outputs
  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      O_AUX_SEQ          <= SEQ_RST;
      O_AUX_SUPPLY       <= SUP_RST;
      O_AUX_FORCE_ACTIVE <= 1'b0;
      O_AUX_FORCE_OFF    <= 1'b0;
      O_AUX_LOW_WHEN_ON  <= 1'b1;
      O_AUX_OPEN_DRAIN   <= 1'b1;
    end else if (I_CE) begin
      O_AUX_SEQ          <= seq_code;
      O_AUX_SUPPLY       <= sup_code;
      O_AUX_FORCE_ACTIVE <= (seq_mode == conv_cfg_pkg::SEQ_FORCE_ACTIVE);
      O_AUX_FORCE_OFF    <= (seq_mode == conv_cfg_pkg::SEQ_FORCE_OFF);
      O_AUX_LOW_WHEN_ON  <= (seq_mode == conv_cfg_pkg::SEQ_LOW_WHEN_ON);
      O_AUX_OPEN_DRAIN   <= (sup_mode == conv_cfg_pkg::SUP_OPEN_DRAIN);
    end
  end

  // Current set pin and monitor window outputs
  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      O_CURRENT_SET_PIN_PIN_ACTIVE <= CMC_RST[conv_cfg_pkg::CURRENT_SET_PIN_OVERRIDE_BIT];
      O_CURRENT_LIMIT_DAC_DAC_ENABLE <= ~CMC_RST[conv_cfg_pkg::CURRENT_SET_PIN_OVERRIDE_BIT];
      O_WIN_LOW_CODE    <= WIN_RST;
      O_WIN_LOW_PERMIL  <= WIN_PERMIL_RST;
      O_WIN_LOW_ENABLE  <= (WIN_RST != 5'h00);
    end else if (I_CE) begin
      O_CURRENT_SET_PIN_PIN_ACTIVE <= cmc_q[conv_cfg_pkg::CURRENT_SET_PIN_OVERRIDE_BIT];
      O_CURRENT_LIMIT_DAC_DAC_ENABLE <= ~cmc_q[conv_cfg_pkg::CURRENT_SET_PIN_OVERRIDE_BIT];
      O_WIN_LOW_CODE    <= win_code;
      O_WIN_LOW_PERMIL  <= win_permil;
      O_WIN_LOW_ENABLE  <= (win_code != 5'h00);
    end
  end

  // Input overvoltage outputs
  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      O_IN_OV_CODE <= OVT_RST;
      O_IN_OV_MV   <= OV_MV_RST;
    end else if (I_CE) begin
      O_IN_OV_CODE <= ovt_q;
      O_IN_OV_MV   <= ov_mv;
    end
  end

endmodule : conv_cfg_regs

/* File: conv_cfg_regs_properties.sv */
module conv_cfg_regs_checker (
  // Clock, reset, enable
  input wire logic        I_CLK,
  input wire logic        I_RST_N,
  input wire logic        I_CE,
  // Register port
  input wire logic [7:0]  I_REG_ADDR,
  input wire logic        I_REG_WR,
  input wire logic [7:0]  I_REG_WDATA,
  input wire logic        I_REG_RD,
  input wire logic [7:0]  O_REG_RDATA,
  input wire logic        O_REG_RVALID,
  input wire logic        O_REG_HIT,
  // Field outputs
  input wire logic        O_FB_DIV20,
  input wire logic [11:0] O_LLC_GAIN_MV,
  input wire logic [1:0]  O_AUX_SEQ,
  input wire logic        O_AUX_FORCE_OFF,
  input wire logic [1:0]  O_AUX_SUPPLY,
  input wire logic        O_AUX_OPEN_DRAIN,
  input wire logic        O_CURRENT_SET_PIN_PIN_ACTIVE,
  input wire logic        O_CURRENT_LIMIT_DAC_DAC_ENABLE,
  input wire logic [4:0]  O_WIN_LOW_CODE,
  input wire logic [9:0]  O_WIN_LOW_PERMIL,
  input wire logic [7:0]  O_IN_OV_CODE,
  input wire logic [15:0] O_IN_OV_MV
);
  default clocking cb @(posedge I_CLK);
  endclocking
  default disable iff (!I_RST_N);
  // Output/driver fields follow a write two edges later
  sequence s_wr_d8;
    I_CE && I_REG_WR && I_REG_ADDR == 8'hD8 ##1 I_CE;
  endsequence
  property p_fb_div;
    s_wr_d8 |=> O_FB_DIV20 == $past(I_REG_WDATA[7], 2);
  endproperty
  a_fb_div: assert property (p_fb_div)
    else $error("feedback ratio output wrong");
  property p_gain_mv;
    s_wr_d8 |=> O_LLC_GAIN_MV == (12'h0FA << $past(I_REG_WDATA[5:4], 2));
  endproperty
  a_gain_mv: assert property (p_gain_mv)
    else $error("compensation gain wrong");
  property p_seq_decode;
    s_wr_d8 |=> O_AUX_SEQ == $past(I_REG_WDATA[3:2], 2) &&
      O_AUX_FORCE_OFF == ($past(I_REG_WDATA[3:2], 2) == 2'h3);
  endproperty
  a_seq_decode: assert property (p_seq_decode)
    else $error("sequencing decode wrong");
  property p_sup_decode;
    O_AUX_OPEN_DRAIN == (O_AUX_SUPPLY == 2'h0);
  endproperty
  a_sup_decode: assert property (p_sup_decode)
    else $error("supply decode wrong");
  // Monitor register reads and writes, overvoltage register writes, and address decode
  property p_nil_read;
    I_CE && I_REG_RD && I_REG_ADDR == 8'hD9 |=>
      O_REG_RVALID && O_REG_HIT && O_REG_RDATA[7:6] == 2'h0;
  endproperty
  a_nil_read: assert property (p_nil_read)
    else $error("unimplemented bits read nonzero");
  property p_mon_write;
    I_CE && I_REG_WR && I_REG_ADDR == 8'hD9 ##1 I_CE |=>
      {O_CURRENT_SET_PIN_PIN_ACTIVE, O_WIN_LOW_CODE} == $past(I_REG_WDATA[5:0], 2) &&
      O_CURRENT_LIMIT_DAC_DAC_ENABLE != O_CURRENT_SET_PIN_PIN_ACTIVE;
  endproperty
  a_mon_write: assert property (p_mon_write)
    else $error("pin override or window wrong");
  property p_win_scale;
    O_WIN_LOW_PERMIL == 10'h019 * O_WIN_LOW_CODE;
  endproperty
  a_win_scale: assert property (p_win_scale)
    else $error("window scaling wrong");
  property p_ov_write;
    I_CE && I_REG_WR && I_REG_ADDR == 8'hDA ##1 I_CE |=>
      O_IN_OV_CODE == $past(I_REG_WDATA, 2) &&
      O_IN_OV_MV == 16'h128E + 16'h007D * $past(I_REG_WDATA, 2);
  endproperty
  a_ov_write: assert property (p_ov_write)
    else $error("overvoltage threshold wrong");
  property p_hit;
    I_CE && I_REG_RD && !I_REG_WR |=> O_REG_RVALID &&
      O_REG_HIT == ($past(I_REG_ADDR) inside {8'hD8, 8'hD9, 8'hDA});
  endproperty
  a_hit: assert property (p_hit)
    else $error("address decode wrong");
endmodule : conv_cfg_regs_checker

/* File: conv_host_model.sv */
module conv_host_model (
  // Clock
  input  wire logic       i_clk,
  // Requests
  output logic [7:0]      o_addr,
  output logic            o_wr,
  output logic [7:0]      o_wdata,
  output logic            o_rd,
  // Answers
  input  wire logic [7:0] i_rdata,
  input  wire logic       i_rvalid,
  input  wire logic       i_hit
);
  timeunit 1ns;
  timeprecision 1ns;
  // Idle bus
  initial begin
    o_addr = 8'h00;
    o_wr = 1'b0;
    o_wdata = 8'h00;
    o_rd = 1'b0;
  end
  // One-cycle write strobe; released lines show the inverse value
  task automatic write(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    o_addr <= a;
    o_wdata <= d;
    o_wr <= 1'b1;
    @(posedge i_clk);
    o_wr <= 1'b0;
    o_addr <= ~a;
    o_wdata <= ~d;
  endtask : write
  // One-cycle read strobe; answer sampled just after the taking edge
  task automatic read(input logic [7:0] a, output logic [9:0] r);
    @(posedge i_clk);
    o_addr <= a;
    o_rd <= 1'b1;
    @(posedge i_clk);
    o_rd <= 1'b0;
    o_addr <= ~a;
    #1 r = {i_hit, i_rvalid, i_rdata};
  endtask : read
endmodule : conv_host_model

/* File: tb_conv_cfg_regs.sv */
module tb_conv_cfg_regs;
  timeunit 1ns;
  timeprecision 1ns;
  logic        I_CLK, I_RST_N, I_CE, I_REG_WR, I_REG_RD;
  logic [7:0]  I_REG_ADDR, I_REG_WDATA, O_REG_RDATA, O_IN_OV_CODE;
  logic        O_AUX_FORCE_ACTIVE, O_AUX_FORCE_OFF, O_AUX_LOW_WHEN_ON;
  logic        O_AUX_OPEN_DRAIN;
  logic        O_REG_RVALID, O_REG_HIT, O_FB_DIV20, O_LLC_ENABLE;
  logic        O_CURRENT_SET_PIN_PIN_ACTIVE, O_CURRENT_LIMIT_DAC_DAC_ENABLE, O_WIN_LOW_ENABLE;
  logic [1:0]  O_LLC_GAIN, O_AUX_SEQ, O_AUX_SUPPLY;
  logic [11:0] O_LLC_GAIN_MV;
  logic [4:0]  O_WIN_LOW_CODE;
  logic [9:0]  O_WIN_LOW_PERMIL, r;
  logic [15:0] O_IN_OV_MV;
  logic [7:0]  v8 [4] = '{8'h00, 8'h55, 8'hAA, 8'hFF};
  int          err_total, total_checks;
  // Design and host
  conv_cfg_regs conv_cfg_regs_i (
    .I_CLK, .I_RST_N, .I_CE, .I_REG_ADDR, .I_REG_WR, .I_REG_WDATA,
    .I_REG_RD, .O_REG_RDATA, .O_REG_RVALID, .O_REG_HIT, .O_FB_DIV20,
    .O_LLC_ENABLE, .O_LLC_GAIN, .O_LLC_GAIN_MV, .O_AUX_SEQ,
    .O_AUX_SUPPLY, .O_AUX_FORCE_ACTIVE, .O_AUX_FORCE_OFF,
    .O_AUX_LOW_WHEN_ON, .O_AUX_OPEN_DRAIN, .O_CURRENT_SET_PIN_PIN_ACTIVE,
    .O_CURRENT_LIMIT_DAC_DAC_ENABLE, .O_WIN_LOW_CODE, .O_WIN_LOW_PERMIL,
    .O_WIN_LOW_ENABLE, .O_IN_OV_CODE, .O_IN_OV_MV);
  conv_host_model conv_host_model_i (
    .i_clk(I_CLK), .o_addr(I_REG_ADDR), .o_wr(I_REG_WR),
    .o_wdata(I_REG_WDATA), .o_rd(I_REG_RD), .i_rdata(O_REG_RDATA),
    .i_rvalid(O_REG_RVALID), .i_hit(O_REG_HIT));
  // 20 MHz clock
  initial begin
    I_CLK = 1'b0;
    forever #25 I_CLK = ~I_CLK;
  end
  // Compare and count
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // Read and compare {hit, valid, data}
  task automatic rchk(input logic [7:0] a, input logic [9:0] e);
    conv_host_model_i.read(a, r);
    chk(16'(r), 16'(e));
  endtask : rchk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    conv_host_model_i.write(a, d);
  endtask : wr
  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : complete_run
  // Hold reset for 20 cycles, release, then compare the three register reset values and the field outputs except O_LLC_GAIN
  task automatic reset_check();
    I_RST_N <= 1'b0;
    repeat (20) @(posedge I_CLK);
    I_RST_N <= 1'b1;
    rchk(8'hD8, 10'h384);
    rchk(8'hD9, 10'h32C);
    rchk(8'hDA, 10'h3FF);
    chk(16'({O_FB_DIV20, O_LLC_ENABLE}), 16'h0002);
    chk(16'(O_LLC_GAIN_MV), 16'h00FA);
    chk(16'({O_AUX_SEQ, O_AUX_SUPPLY}), 16'h0004);
    chk(16'({O_AUX_FORCE_ACTIVE, O_AUX_FORCE_OFF}), 16'h0000);
    chk(16'({O_AUX_LOW_WHEN_ON, O_AUX_OPEN_DRAIN}), 16'h0003);
    chk(16'({O_CURRENT_SET_PIN_PIN_ACTIVE, O_CURRENT_LIMIT_DAC_DAC_ENABLE}), 16'h0002);
    chk(16'({O_WIN_LOW_ENABLE, O_WIN_LOW_CODE}), 16'h002C);
    chk(16'(O_WIN_LOW_PERMIL), 16'h012C);
    chk(16'(O_IN_OV_CODE), 16'h00FF);
    chk(O_IN_OV_MV, 16'h8F11);
  endtask : reset_check
  // Watchdog
  initial begin
    #200_000;
    err_total++;
    complete_run();
  end
  // Test sequence
  initial begin
    I_CE <= 1'b1;
    reset_check();
    $display("reset values done");
    foreach (v8[i]) begin
      wr(8'hD8, v8[i]);
      rchk(8'hD8, {2'h3, v8[i]});
      chk(16'(O_FB_DIV20), 16'(v8[i][7]));
      chk(16'(O_LLC_ENABLE), 16'(v8[i][6]));
      chk(16'(O_LLC_GAIN), 16'(v8[i][5:4]));
      chk(16'(O_LLC_GAIN_MV), 16'h00FA << v8[i][5:4]);
      chk(16'(O_AUX_SEQ), 16'(v8[i][3:2]));
      chk(16'(O_AUX_SUPPLY), 16'(v8[i][1:0]));
      chk(16'(O_AUX_FORCE_ACTIVE), 16'(v8[i][3:2] == 2'h2));
      chk(16'(O_AUX_FORCE_OFF), 16'(v8[i][3:2] == 2'h3));
      chk(16'(O_AUX_LOW_WHEN_ON), 16'(v8[i][3:2] == 2'h1));
      chk(16'(O_AUX_OPEN_DRAIN), 16'(v8[i][1:0] == 2'h0));
    end
    $display("output driver codes done");
    wr(8'hD9, 8'hFF);
    rchk(8'hD9, 10'h33F);
    chk(16'({O_CURRENT_SET_PIN_PIN_ACTIVE, O_CURRENT_LIMIT_DAC_DAC_ENABLE}), 16'h0002);
    chk(16'({O_WIN_LOW_ENABLE, O_WIN_LOW_CODE}), 16'h003F);
    chk(16'(O_WIN_LOW_PERMIL), 16'h0307);
    wr(8'hD9, 8'h00);
    rchk(8'hD9, 10'h300);
    chk(16'({O_CURRENT_SET_PIN_PIN_ACTIVE, O_CURRENT_LIMIT_DAC_DAC_ENABLE}), 16'h0001);
    chk(16'({O_WIN_LOW_ENABLE, O_WIN_LOW_CODE}), 16'h0000);
    chk(16'(O_WIN_LOW_PERMIL), 16'h0000);
    $display("monitor register done");
    wr(8'hDA, 8'h3F);
    rchk(8'hDA, 10'h33F);
    chk(16'(O_IN_OV_CODE), 16'h003F);
    chk(O_IN_OV_MV, 16'h3151);
    wr(8'hDA, 8'h00);
    rchk(8'hDA, 10'h300);
    chk(16'(O_IN_OV_CODE), 16'h0000);
    chk(O_IN_OV_MV, 16'h128E);
    $display("overvoltage register done");
    wr(8'hDB, 8'h5A);
    rchk(8'hDB, 10'h100);
    @(posedge I_CLK);
    I_CE <= 1'b0;
    wr(8'hD8, 8'h00);
    I_CE <= 1'b1;
    rchk(8'hD8, 10'h3FF);
    $display("unmapped and enable done");
    reset_check();
    $display("mid-run reset done");
    complete_run();
  end
endmodule : tb_conv_cfg_regs
bind conv_cfg_regs conv_cfg_regs_checker conv_cfg_regs_checker_i (
  .I_CLK, .I_RST_N, .I_CE, .I_REG_ADDR, .I_REG_WR, .I_REG_WDATA,
  .I_REG_RD, .O_REG_RDATA, .O_REG_RVALID, .O_REG_HIT, .O_FB_DIV20,
  .O_LLC_GAIN_MV, .O_AUX_SEQ, .O_AUX_FORCE_OFF, .O_AUX_SUPPLY,
  .O_AUX_OPEN_DRAIN, .O_CURRENT_SET_PIN_PIN_ACTIVE, .O_CURRENT_LIMIT_DAC_DAC_ENABLE,
  .O_WIN_LOW_CODE, .O_WIN_LOW_PERMIL, .O_IN_OV_CODE, .O_IN_OV_MV);
